// file: hw/rfs_ref_select.sv
// Reference frequency selector: presets, PID command pick, jump bands, jog state.
// Assumes all inputs synchronous to ref_clk and settings held steady while used.
//
// Overview of operation
// RULE1: Four select inputs form index 1-15 picking a preset; zero picks normal source.
// RULE2: Presets range 0 to 500.00 Hz in 0.01 Hz steps.
// RULE3: Select inputs act only through terminals assigned codes 0 to 3.
// RULE4: In PID modes 1-3, weights 8 and 4 pick source, preset 4, 8 or 12.
// RULE5: With PID cancelled, weights 2 and 1 pick manual presets 1-3.
// RULE6: PID preset in whole hertz; percent equals preset over maximum frequency times 100.
// RULE7: Three jump centres 0-500.0 Hz; zero centre disables that band.
// RULE8: Common width 0-30.0 Hz sets band extent; zero disables all bands.
// RULE9: Rising into a band holds the lower edge until the upper edge is passed.
// RULE10: Falling into a band holds the upper edge until below the lower edge.
// RULE11: Overlapping bands merge into one band spanning their outermost edges.
// RULE12: Jog terminal (function 10) puts the drive into jog-ready state.
// RULE13: Jog-ready state changes only while the drive is stopped.
// RULE14: With keypad run source 0, 2 or 3, key pair toggles jog-ready.
// RULE15: Controller sets jog parameters and enters jog-ready before giving a run command.
// RULE16: While jogging the reference is the jog frequency, 0-500.00 Hz.
// RULE17: Jog and run within 100 ms start jogging; run clearly first runs normally.
// RULE18: Reference is registered; reset returns selection to the non-preset source.
// RULE19: Jump bands act on the selected reference before it leaves the block.
`timescale 1ns/100ps
module rfs_ref_select #(
    parameter int N_TERM = 9,
    parameter int JOG_WINDOW = rfs_pkg::JOG_WINDOW_CYC
) (
    input wire logic ref_clk,                                   // System clock
    input wire logic rst_b,                                     // Async reset, active low
    input wire logic [N_TERM-1:0] dig_in,                       // Digital input terminal levels
    input wire logic [N_TERM*rfs_pkg::TERM_FUNC_W-1:0] term_func, // Function code per terminal
    input wire rfs_pkg::rfs_freq_t [rfs_pkg::PRESET_NUM-1:0] preset_freq, // Presets 1..15
    input wire rfs_pkg::rfs_freq_t primary_freq_cmd,            // Primary frequency command
    input wire rfs_pkg::rfs_freq_t secondary_freq_cmd,          // Secondary frequency command
    input wire logic use_secondary,                             // Normal source picks secondary
    input wire logic [1:0] pid_mode_select,                     // PID mode, 0 off
    input wire logic pid_cancel_cmd,                            // PID cancelled, manual speed
    input wire logic [rfs_pkg::PCT_W-1:0] pid_command_source,   // Configured PID command, 0.01 %
    input wire rfs_pkg::rfs_freq_t max_output_freq,             // Maximum output frequency
    input wire logic [rfs_pkg::JUMP_W-1:0] jump_center_1,       // Jump centre 1, 0.1 Hz
    input wire logic [rfs_pkg::JUMP_W-1:0] jump_center_2,       // Jump centre 2, 0.1 Hz
    input wire logic [rfs_pkg::JUMP_W-1:0] jump_center_3,       // Jump centre 3, 0.1 Hz
    input wire logic [rfs_pkg::HYST_W-1:0] jump_hysteresis_width, // Band width, 0.1 Hz
    input wire logic [1:0] run_cmd_source,                      // Run command source setting
    input wire logic jog_keys,                                  // Keypad jog key pair held
    input wire logic forward_run_cmd,                           // Run command level
    input wire logic drive_stopped,                             // Drive output stopped
    input wire rfs_pkg::rfs_freq_t jog_frequency,               // Jog frequency
    output rfs_pkg::rfs_freq_t ref_freq,                        // Internal reference, 0.01 Hz
    output logic [3:0] preset_idx,                              // Preset in use, 0 none
    output logic [rfs_pkg::PCT_W-1:0] pid_cmd,                  // PID command, 0.01 %
    output logic pid_from_source,                               // PID command from source
    output logic jog_ready,                                     // Jog-ready state
    output logic jogging                                        // Jog operation active
);
    rfs_pkg::rfs_state_t s_r;
    rfs_pkg::rfs_state_t s_nxt;
    rfs_pkg::rfs_band_t [2:0] band;
    logic [3:0] sel_code;
    logic jog_term;
    logic pid_on;
    logic [rfs_pkg::TERM_FUNC_W-1:0] fcode;
    rfs_pkg::rfs_freq_t req;
    rfs_pkg::rfs_freq_t pid_pre;
    logic [31:0] pct_wide;
    logic hit;
    rfs_pkg::rfs_freq_t m_lo;
    rfs_pkg::rfs_freq_t m_hi;
    logic keypad_src;
    logic run_rise;
    logic jog_rise;

    rfs_jump_band u_band1 (.center(jump_center_1), .width(jump_hysteresis_width), .band(band[0]));
    rfs_jump_band u_band2 (.center(jump_center_2), .width(jump_hysteresis_width), .band(band[1]));
    rfs_jump_band u_band3 (.center(jump_center_3), .width(jump_hysteresis_width), .band(band[2]));

    function automatic rfs_pkg::rfs_freq_t clamp_f(input rfs_pkg::rfs_freq_t f);
        clamp_f = (f > rfs_pkg::FREQ_MAX) ? rfs_pkg::FREQ_MAX : f;
    endfunction : clamp_f

    function automatic rfs_pkg::rfs_freq_t preset(input logic [3:0] n);
        // Index zero has no preset slot; keep the read in range
        preset = (n == rfs_pkg::SEL_NONE) ? rfs_pkg::FREQ_ZERO
            : clamp_f(preset_freq[n - 4'h1]); // [RULE2]
    endfunction : preset

    always_comb begin
        // Terminal decode: only assigned terminals drive selects
        sel_code = '0;
        jog_term = 1'b0;
        for (int i = 0; i < N_TERM; i++) begin
            fcode = term_func[i*rfs_pkg::TERM_FUNC_W +: rfs_pkg::TERM_FUNC_W];
            if (dig_in[i]) begin
                if (fcode == rfs_pkg::FUNC_SEL_W1) sel_code[0] = 1'b1; // [RULE3]
                if (fcode == rfs_pkg::FUNC_SEL_W2) sel_code[1] = 1'b1; // [RULE3]
                if (fcode == rfs_pkg::FUNC_SEL_W4) sel_code[2] = 1'b1; // [RULE3]
                if (fcode == rfs_pkg::FUNC_SEL_W8) sel_code[3] = 1'b1; // [RULE3]
                if (fcode == rfs_pkg::FUNC_JOG) jog_term = 1'b1; // [RULE12]
            end
        end
    end

    always_comb begin
        s_nxt = s_r;
        pid_on = (pid_mode_select != rfs_pkg::PID_MODE_OFF);
        keypad_src = (run_cmd_source == rfs_pkg::RUN_SRC_KEYPAD_A)
            || (run_cmd_source == rfs_pkg::RUN_SRC_KEYPAD_B)
            || (run_cmd_source == rfs_pkg::RUN_SRC_KEYPAD_C);
        run_rise = forward_run_cmd && !s_r.run_d;
        jog_rise = jog_term && !s_r.jog_term_d;
        s_nxt.run_d = forward_run_cmd;
        s_nxt.jog_term_d = jog_term;
        s_nxt.key_d = jog_keys;

        // Frequency selection
        s_nxt.preset_idx = pid_on ? {2'b00, sel_code[1:0]} : sel_code; // [RULE1] [RULE5]
        if (s_nxt.preset_idx == rfs_pkg::SEL_NONE) begin
            req = use_secondary ? clamp_f(secondary_freq_cmd) : clamp_f(primary_freq_cmd); // [RULE1]
        end else begin
            req = preset(s_nxt.preset_idx); // [RULE1]
        end

        // PID command: weights 8 and 4 only
        s_nxt.pid_ext = (sel_code[3:2] == 2'b00); // [RULE4]
        pid_pre = preset({sel_code[3:2], 2'b00}); // [RULE4]
        pid_pre = rfs_pkg::FREQ_W'((pid_pre / rfs_pkg::FREQ_W'(rfs_pkg::HUNDREDTHS_PER_HZ))
            * rfs_pkg::FREQ_W'(rfs_pkg::HUNDREDTHS_PER_HZ)); // [RULE6]
        pct_wide = (max_output_freq == rfs_pkg::FREQ_ZERO) ? '0
            : (32'(pid_pre) * 32'(rfs_pkg::PCT_SCALE)) / 32'(max_output_freq); // [RULE6]
        if (!pid_on) begin
            s_nxt.pid_cmd = '0;
        end else if (s_nxt.pid_ext) begin
            s_nxt.pid_cmd = pid_command_source; // [RULE4]
        end else begin
            s_nxt.pid_cmd = (pct_wide > 32'(rfs_pkg::PCT_SCALE))
                ? rfs_pkg::PCT_W'(rfs_pkg::PCT_SCALE) : rfs_pkg::PCT_W'(pct_wide); // [RULE6]
        end

        // Jog state, only while stopped
        if (drive_stopped) begin
            if (jog_rise) s_nxt.jog_ready = 1'b1; // [RULE12] [RULE13]
            else if (!jog_term && s_r.jog_term_d) s_nxt.jog_ready = 1'b0; // [RULE13]
            else if (keypad_src && jog_keys && !s_r.key_d) s_nxt.jog_ready = !s_r.jog_ready; // [RULE14]
        end

        // Jog start: ready before run, or jog within window after run
        if (!forward_run_cmd) begin
            s_nxt.jogging = 1'b0;
            s_nxt.win_open = 1'b0;
        end else if (run_rise) begin
            s_nxt.jogging = s_r.jog_ready || jog_term; // [RULE15] [RULE17]
            s_nxt.win_open = !(s_r.jog_ready || jog_term); // [RULE17]
            s_nxt.win_cnt = '0;
        end else if (s_r.win_open) begin
            if (jog_term) begin
                s_nxt.jogging = 1'b1; // [RULE17]
                s_nxt.win_open = 1'b0;
            end else if (s_r.win_cnt >= rfs_pkg::WIN_W'(JOG_WINDOW - 1)) begin
                s_nxt.win_open = 1'b0; // [RULE17]
            end else begin
                s_nxt.win_cnt = s_r.win_cnt + 1'b1;
            end
        end
        if (s_nxt.jogging) begin
            req = clamp_f(jog_frequency); // [RULE16]
        end

        // Merged jump band around the request
        hit = 1'b0;
        m_lo = '0;
        m_hi = '0;
        for (int i = 0; i < 3; i++) begin
            if (!hit && band[i].en && req >= band[i].lo && req <= band[i].hi) begin
                hit = 1'b1;
                m_lo = band[i].lo;
                m_hi = band[i].hi;
            end
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 3; i++) begin
                if (hit && band[i].en && band[i].lo <= m_hi && band[i].hi >= m_lo) begin
                    if (band[i].lo < m_lo) m_lo = band[i].lo; // [RULE11]
                    if (band[i].hi > m_hi) m_hi = band[i].hi; // [RULE11]
                end
            end
        end

        // Jump processing on the selected request
        s_nxt.prev_req = req;
        if (!hit) begin
            s_nxt.jst = rfs_pkg::JMP_FOLLOW;
        end else if (s_r.jst == rfs_pkg::JMP_FOLLOW) begin
            s_nxt.jst = (req >= s_r.prev_req) ? rfs_pkg::JMP_HOLD_LO : rfs_pkg::JMP_HOLD_HI;
        end
        unique case (s_nxt.jst)
            rfs_pkg::JMP_FOLLOW: s_nxt.ref_freq = req; // [RULE19]
            rfs_pkg::JMP_HOLD_LO: s_nxt.ref_freq = m_lo; // [RULE9]
            rfs_pkg::JMP_HOLD_HI: s_nxt.ref_freq = m_hi; // [RULE10]
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{jst: rfs_pkg::JMP_FOLLOW, preset_idx: rfs_pkg::SEL_NONE, default: '0}; // [RULE18]
        end else begin
            s_r <= s_nxt; // [RULE18]
        end
    end

    assign ref_freq = s_r.ref_freq;
    assign preset_idx = s_r.preset_idx;
    assign pid_cmd = s_r.pid_cmd;
    assign pid_from_source = s_r.pid_ext;
    assign jog_ready = s_r.jog_ready;
    assign jogging = s_r.jogging;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_run_with_ready;
        !forward_run_cmd && jog_ready ##1 forward_run_cmd && jog_ready;
    endsequence

    sequence s_run_alone;
        !forward_run_cmd && !jog_ready && !jog_term ##1 forward_run_cmd && !jog_ready && !jog_term;
    endsequence

    a_preset_decode: assert property (!pid_on |=> preset_idx == $past(sel_code)) // [RULE1]
        else $error("preset index does not follow select inputs");
    a_preset_range: assert property (ref_freq <= rfs_pkg::FREQ_MAX) // [RULE2]
        else $error("reference above 500 Hz");
    a_pid_source: assert property (pid_on && sel_code[3:2] == 2'b00 |=> pid_from_source // [RULE4]
        && pid_cmd == $past(pid_command_source))
        else $error("PID command not taken from source");
    a_manual_ignore: assert property (pid_on |=> preset_idx[3:2] == 2'b00) // [RULE5]
        else $error("weights 8 and 4 used for manual speed under PID");
    a_hold_lower: assert property (s_nxt.jst == rfs_pkg::JMP_HOLD_LO |=> ref_freq == $past(m_lo)) // [RULE9]
        else $error("reference not held at band lower edge");
    a_hold_upper: assert property (s_nxt.jst == rfs_pkg::JMP_HOLD_HI |=> ref_freq == $past(m_hi)) // [RULE10]
        else $error("reference not held at band upper edge");
    a_jog_stopped: assert property (!drive_stopped |=> $stable(jog_ready)) // [RULE13]
        else $error("jog-ready changed while running");
    a_key_toggle: assert property (drive_stopped && keypad_src && jog_keys && !s_r.key_d // [RULE14]
        && !jog_term && !s_r.jog_term_d |=> jog_ready != $past(jog_ready))
        else $error("keypad key pair did not toggle jog-ready");
    a_jog_start: assert property (s_run_with_ready |=> jogging) // [RULE17]
        else $error("run with jog-ready did not start jogging");
    a_run_normal: assert property (s_run_alone ##1 !jog_term [*2] |-> !jogging) // [RULE17]
        else $error("run alone started jogging");
    a_jog_ref: assert property (s_nxt.jogging && !hit && jog_frequency <= rfs_pkg::FREQ_MAX // [RULE16]
        |=> ref_freq == $past(jog_frequency))
        else $error("jog reference not used while jogging");

endmodule : rfs_ref_select

// file: hw/rfs_pkg.sv
// Constants, types and state layout for the reference frequency selector.
// Assumes a 200 MHz system clock; frequencies are carried in 0.01 Hz units.
package rfs_pkg;

    localparam int FREQ_W = 16;
    localparam int PRESET_NUM = 15;
    localparam int TERM_FUNC_W = 8;
    localparam int PCT_W = 14;
    localparam int JUMP_W = 13;
    localparam int HYST_W = 9;

    // Frequency ranges (0.01 Hz for presets/jog, 0.1 Hz for jump settings)
    localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hc350;
    localparam logic [JUMP_W-1:0] JUMP_MAX = 13'h1388;
    localparam logic [HYST_W-1:0] HYST_MAX = 9'h12c;
    localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;

    // Unit conversions
    localparam int TENTH_TO_HUNDREDTH = 10;
    localparam int HALF_TENTH_TO_HUNDREDTH = 5;
    localparam int HUNDREDTHS_PER_HZ = 100;
    localparam int PCT_SCALE = 10000;

    // Terminal function codes
    localparam logic [TERM_FUNC_W-1:0] FUNC_SEL_W1 = 8'h00;
    localparam logic [TERM_FUNC_W-1:0] FUNC_SEL_W2 = 8'h01;
    localparam logic [TERM_FUNC_W-1:0] FUNC_SEL_W4 = 8'h02;
    localparam logic [TERM_FUNC_W-1:0] FUNC_SEL_W8 = 8'h03;
    localparam logic [TERM_FUNC_W-1:0] FUNC_JOG = 8'h0a;

    // Mode codes
    localparam logic [1:0] PID_MODE_OFF = 2'h0;
    localparam logic [1:0] RUN_SRC_KEYPAD_A = 2'h0;
    localparam logic [1:0] RUN_SRC_KEYPAD_B = 2'h2;
    localparam logic [1:0] RUN_SRC_KEYPAD_C = 2'h3;

    // Jog/run coincidence window
    localparam int CLK_MHZ = 200;
    localparam int JOG_WINDOW_MS = 100;
    localparam int JOG_WINDOW_CYC = JOG_WINDOW_MS * CLK_MHZ * 1000;
    localparam int WIN_W = 25;

    localparam logic [3:0] SEL_NONE = 4'h0;

    typedef logic [FREQ_W-1:0] rfs_freq_t;

    typedef enum logic [1:0] {
        JMP_FOLLOW,
        JMP_HOLD_LO,
        JMP_HOLD_HI
    } rfs_jump_st_t;

    typedef struct packed {
        logic en;
        rfs_freq_t lo;
        rfs_freq_t hi;
    } rfs_band_t;

    typedef struct packed {
        rfs_freq_t ref_freq;
        logic [3:0] preset_idx;
        logic [PCT_W-1:0] pid_cmd;
        logic pid_ext;
        rfs_jump_st_t jst;
        rfs_freq_t prev_req;
        logic jog_ready;
        logic jogging;
        logic jog_term_d;
        logic key_d;
        logic run_d;
        logic win_open;
        logic [WIN_W-1:0] win_cnt;
    } rfs_state_t;

endpackage : rfs_pkg

// file: hw/rfs_jump_band.sv
// One jump band: turns a centre and a common width into band edges.
// Assumes settings are quasi-static configuration values.
`timescale 1ns/100ps
module rfs_jump_band (
    input wire logic [rfs_pkg::JUMP_W-1:0] center, // Centre, 0.1 Hz
    input wire logic [rfs_pkg::HYST_W-1:0] width,  // Width, 0.1 Hz
    output rfs_pkg::rfs_band_t band                // Edges in 0.01 Hz
);
    logic [16:0] c_h;
    logic [16:0] half_w;

    always_comb begin
        c_h = 17'(center) * 17'(rfs_pkg::TENTH_TO_HUNDREDTH);
        half_w = 17'(width) * 17'(rfs_pkg::HALF_TENTH_TO_HUNDREDTH);
        // Zero centre or zero width switches the band off
        band.en = (center != '0) && (width != '0)
            && (center <= rfs_pkg::JUMP_MAX) && (width <= rfs_pkg::HYST_MAX); // [RULE7] [RULE8]
        band.lo = (c_h > half_w) ? 16'(c_h - half_w) : rfs_pkg::FREQ_ZERO; // [RULE8]
        band.hi = 16'(c_h + half_w); // [RULE8]
    end

endmodule : rfs_jump_band

// file: verif/rfs_term_model.sv
// Far-side model: terminal wiring and assignment of select weights and jog.
// Assumes the bench drives sel and jog_req; spare terminals carry noise.
`timescale 1ns/100ps
module rfs_term_model #(
    parameter int N_TERM = 9
) (
    input wire logic ref_clk,                                  // System clock
    input wire logic [3:0] sel,                                // Weights 8,4,2,1
    input wire logic jog_req,                                  // Jog terminal level
    output logic [N_TERM-1:0] dig_in,                          // Terminal levels
    output logic [N_TERM*rfs_pkg::TERM_FUNC_W-1:0] term_func   // Function codes
);
    logic [N_TERM-1:0] noise_r = '0;

    always @(posedge ref_clk) begin
        noise_r <= ~noise_r;
    end

    // Weights sit on shuffled terminals; spare ones toggle under a dead code
    always_comb begin
        dig_in = noise_r;
        term_func = {N_TERM{8'h63}};
        term_func[5*8 +: 8] = rfs_pkg::FUNC_SEL_W1;
        term_func[2*8 +: 8] = rfs_pkg::FUNC_SEL_W2;
        term_func[7*8 +: 8] = rfs_pkg::FUNC_SEL_W4;
        term_func[0*8 +: 8] = rfs_pkg::FUNC_SEL_W8;
        term_func[3*8 +: 8] = rfs_pkg::FUNC_JOG;
        dig_in[5] = sel[0];
        dig_in[2] = sel[1];
        dig_in[7] = sel[2];
        dig_in[0] = sel[3];
        dig_in[3] = jog_req;
    end
endmodule : rfs_term_model

// file: verif/tb.sv
// Self-checking bench for the reference frequency selector.
// Assumes a 200 MHz clock and a shortened jog coincidence window.
`timescale 1ns/100ps
module tb;
    localparam int N_TERM = 9;
    localparam int WIN = 16;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] sel = 4'h0;
    logic jog_req = 1'b0;
    logic [N_TERM-1:0] dig_in;
    logic [N_TERM*rfs_pkg::TERM_FUNC_W-1:0] term_func;
    rfs_pkg::rfs_freq_t [rfs_pkg::PRESET_NUM-1:0] preset_freq = '0;
    rfs_pkg::rfs_freq_t pri = 16'h0000, sec = 16'h0000, max_f = 16'h1770, jog_f = 16'h0000;
    logic use_sec = 1'b0, pid_cancel = 1'b0, keys = 1'b0, run = 1'b0, stopped = 1'b1, exp_r;
    logic [1:0] pid_mode = 2'h0, run_src = 2'h0;
    logic [rfs_pkg::PCT_W-1:0] pid_src = 14'h0000;
    logic [rfs_pkg::JUMP_W-1:0] c1 = 13'h0000, c2 = 13'h0000, c3 = 13'h0000;
    logic [rfs_pkg::HYST_W-1:0] width = 9'h000;
    rfs_pkg::rfs_freq_t ref_freq;
    logic [3:0] preset_idx;
    logic [rfs_pkg::PCT_W-1:0] pid_cmd;
    logic pid_from_source, jog_ready, jogging;
    int errors = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'h0001453c;
    logic [15:0] jreq [7] = '{16'h12c0, 16'h1356, 16'h141e, 16'h1482, 16'h141e, 16'h1356, 16'h12f2};
    logic [15:0] js [7] = '{16'h12c0, 16'h1324, 16'h141e, 16'h1482, 16'h141e, 16'h13ec, 16'h12f2};
    logic [15:0] jm [7] = '{16'h12c0, 16'h1324, 16'h1324, 16'h1482, 16'h1450, 16'h1450, 16'h12f2};

    rfs_term_model #(.N_TERM(N_TERM)) u_rfs_term_model (.ref_clk(ref_clk), .sel(sel),
        .jog_req(jog_req), .dig_in(dig_in), .term_func(term_func));
    rfs_ref_select #(.N_TERM(N_TERM), .JOG_WINDOW(WIN)) u_rfs_ref_select (.ref_clk(ref_clk),
        .rst_b(rst_b), .dig_in(dig_in), .term_func(term_func), .preset_freq(preset_freq),
        .primary_freq_cmd(pri), .secondary_freq_cmd(sec), .use_secondary(use_sec),
        .pid_mode_select(pid_mode), .pid_cancel_cmd(pid_cancel), .pid_command_source(pid_src),
        .max_output_freq(max_f), .jump_center_1(c1), .jump_center_2(c2),
        .jump_center_3(c3), .jump_hysteresis_width(width), .run_cmd_source(run_src),
        .jog_keys(keys), .forward_run_cmd(run), .drive_stopped(stopped),
        .jog_frequency(jog_f), .ref_freq(ref_freq), .preset_idx(preset_idx),
        .pid_cmd(pid_cmd), .pid_from_source(pid_from_source), .jog_ready(jog_ready),
        .jogging(jogging));

    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // PID percent in 0.01 % from a preset truncated to whole hertz, capped at full scale
    function automatic logic [15:0] pct(input logic [15:0] p, input logic [15:0] m);
        int v;
        v = (int'(p) / 100) * 1000000 / int'(m);
        return (v > 10000) ? 16'h2710 : 16'(v);
    endfunction : pct

    function automatic logic [15:0] exp_ref(input logic [3:0] s, input logic pid);
        logic [3:0] i;
        i = pid ? {2'b00, s[1:0]} : s;
        if (i == 4'h0) return use_sec ? sec : pri;
        return preset_freq[i - 4'h1];
    endfunction : exp_ref

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 15; k++) begin
            seed = lfsr(seed);
            preset_freq[k] <= (k == 14) ? rfs_pkg::FREQ_MAX : 16'(seed % 50001);
        end
        for (int n = 0; n < 48; n++) begin
            @(posedge ref_clk);
            seed = lfsr(seed);
            sel <= (n < 16) ? 4'(n) : seed[3:0];
            use_sec <= seed[4];
            pri <= 16'(seed[31:16] % 50001);
            sec <= 16'(seed[15:0] % 50001);
            settle();
            chk("ref_freq", exp_ref(sel, 1'b0), ref_freq);
            chk("preset_idx", {12'h000, sel}, {12'h000, preset_idx});
            chk("pid_cmd", 16'h0000, {2'b00, pid_cmd});
        end
        $display("test presets done");
        for (int m = 1; m < 4; m++) begin
            for (int s = 0; s < 16; s++) begin
                @(posedge ref_clk);
                seed = lfsr(seed);
                pid_mode <= 2'(m);
                sel <= 4'(s);
                pid_src <= 14'(seed % 10001);
                pid_cancel <= seed[5];
                max_f <= (m == 3) ? 16'h1770 : rfs_pkg::FREQ_MAX;
                settle();
                chk("ref_freq", exp_ref(sel, 1'b1), ref_freq);
                chk("pid_from_source", {15'h0000, sel[3:2] == 2'b00},
                    {15'h0000, pid_from_source});
                chk("pid_cmd", (sel[3:2] == 2'b00) ? {2'b00, pid_src} :
                    pct(preset_freq[{sel[3:2], 2'b00} - 4'h1], max_f), {2'b00, pid_cmd});
            end
        end
        @(posedge ref_clk);
        pid_mode <= 2'h0;
        sel <= 4'h0;
        use_sec <= 1'b0;
        width <= 9'h014;
        c1 <= 13'h01f4;
        $display("test pid done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 7; i++) begin
                @(posedge ref_clk);
                c2 <= (p == 1) ? 13'h01fe : 13'h0000;
                pri <= jreq[i];
                settle();
                chk("ref_freq", (p == 1) ? jm[i] : js[i], ref_freq);
            end
        end
        @(posedge ref_clk);
        c2 <= 13'h0000;
        sel <= 4'h1;
        preset_freq[0] <= 16'h1356;
        settle();
        chk("ref_freq", 16'h1324, ref_freq);
        @(posedge ref_clk);
        c1 <= 13'h0000;
        settle();
        chk("ref_freq", 16'h1356, ref_freq);
        @(posedge ref_clk);
        c1 <= 13'h01f4;
        width <= 9'h000;
        settle();
        chk("ref_freq", 16'h1356, ref_freq);
        // Third band alone catches the same request from below
        @(posedge ref_clk);
        c1 <= 13'h0000;
        c3 <= 13'h01f4;
        width <= 9'h014;
        settle();
        chk("ref_freq", 16'h1324, ref_freq);
        $display("test jump done");
        @(posedge ref_clk);
        jog_f <= 16'h0bb8;
        stopped <= 1'b0;
        jog_req <= 1'b1;
        settle();
        chk("jog_ready", 16'h0000, {15'h0000, jog_ready});
        @(posedge ref_clk);
        jog_req <= 1'b0;
        settle();
        stopped <= 1'b1;
        jog_req <= 1'b1;
        settle();
        chk("jog_ready", 16'h0001, {15'h0000, jog_ready});
        @(posedge ref_clk);
        run <= 1'b1;
        settle();
        chk("jogging", 16'h0001, {15'h0000, jogging});
        chk("ref_freq", jog_f, ref_freq);
        @(posedge ref_clk);
        stopped <= 1'b0;
        jog_req <= 1'b0;
        keys <= 1'b1;
        settle();
        chk("jog_ready", 16'h0001, {15'h0000, jog_ready});
        exp_r = 1'b1;
        for (int r = 0; r < 4; r++) begin
            @(posedge ref_clk);
            run <= 1'b0;
            stopped <= 1'b1;
            keys <= 1'b0;
            run_src <= 2'(r);
            settle();
            keys <= 1'b1;
            settle();
            exp_r = (r == 1) ? exp_r : ~exp_r;
            chk("jog_ready", {15'h0000, exp_r}, {15'h0000, jog_ready});
        end
        @(posedge ref_clk);
        keys <= 1'b0;
        run <= 1'b1;
        repeat (5) @(posedge ref_clk);
        jog_req <= 1'b1;
        settle();
        chk("jogging", 16'h0001, {15'h0000, jogging});
        @(posedge ref_clk);
        run <= 1'b0;
        jog_req <= 1'b0;
        settle();
        run <= 1'b1;
        repeat (WIN + 10) @(posedge ref_clk);
        jog_req <= 1'b1;
        settle();
        chk("jogging", 16'h0000, {15'h0000, jogging});
        $display("test jog done");
        @(posedge ref_clk);
        run <= 1'b0;
        sel <= 4'h7;
        settle();
        rst_b <= 1'b0;
        settle();
        chk("ref_freq", 16'h0000, ref_freq);
        chk("preset_idx", 16'h0000, {12'h000, preset_idx});
        chk("jog_ready", 16'h0000, {15'h0000, jog_ready});
        @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        chk("preset_idx", 16'h0007, {12'h000, preset_idx});
        $display("test reset done");
        end_sim();
    end
endmodule : tb
